//--- design/cxs_sequencer.sv
// Purpose: Exception entry sequencer: status update, vectoring, stacking, vector fetch
// Assumes: Memory bus answers each cycle with memAck; instruction engine holds request
// Notes:   Interrupts are autovectored only; no vector acknowledge cycle exists
//
// Functional notes
// - Copy the status word on entry to every exception except reset.
// - Entry sets the supervisor flag and clears the trace flag.
// - Reset and interrupts also update the priority mask in the status word.
// - Vector number is generated internally and drives the vector address.
// - Non-reset exceptions push a frame on the supervisor stack; reset pushes nothing.
// - Last, fetch new program counter from the vector and resume there.
// - Vector table is 1,024 bytes at address 0, four-byte entries.
// - Interrupt level k uses autovector 24+k; no external acknowledge.
// - Reset loads stack pointer from offset 000 and counter from 004.
// - Trap operand n selects vector 32+n.
// - Opcodes 1010xxxx use vector 10; opcodes 1111xxxx use vector 11.
// - Fault vectors: address 3, illegal 4, divide 5, bounds 6, overflow 7, etc.
// - Vectors 64 to 255 are user vectors, offsets 100 to 3FC.
// - Reset vector fetches use program space; others use data space.
// - Bus cycle order may differ from the functional step order.
// - Traps, divides, bounds, overflow, return, illegal and privilege raise exceptions.
// - Interrupt taken between instructions only when level exceeds the mask.
`timescale 1ns/1ps
`default_nettype none

module cxs_sequencer (
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic             instrBoundary,
    input  wire logic             excReq,
    input  wire cxs_pkg::cxs_req_t excInfo,
    input  wire logic [2:0]       priorityRequestLines,
    input  wire logic [15:0]      statusWordIn,
    input  wire logic             statusWordLoad,
    input  wire logic [31:0]      supStackIn,
    input  wire logic             memAck,
    input  wire logic [15:0]      memRdata,
    output var  cxs_pkg::cxs_bus_t memBus,
    output logic [15:0]           statusWord,
    output logic [31:0]           supervisorStackPointer,
    output logic [31:0]           newPc,
    output logic                  resumeFetch,
    output logic                  busy,
    output logic                  excAccept,
    output logic [7:0]            vectorNumber
);

    // Vector selection shared by faults, traps and user vectors; interrupts take the autovector directly
    function automatic logic [7:0] cxs_vector(input cxs_pkg::cxs_req_t r);
        case (r.cause)
            cxs_pkg::CXS_EX_ADDRERR: cxs_vector = cxs_pkg::CXS_VEC_ADDRERR;
            cxs_pkg::CXS_EX_ILLEGAL: cxs_vector = cxs_pkg::CXS_VEC_ILLEGAL;
            cxs_pkg::CXS_EX_DIVZERO: cxs_vector = cxs_pkg::CXS_VEC_DIVZERO;
            cxs_pkg::CXS_EX_BOUNDS:  cxs_vector = cxs_pkg::CXS_VEC_BOUNDS;
            cxs_pkg::CXS_EX_OVFTRAP: cxs_vector = cxs_pkg::CXS_VEC_OVFTRAP;
            cxs_pkg::CXS_EX_PRIV:    cxs_vector = cxs_pkg::CXS_VEC_PRIV;
            cxs_pkg::CXS_EX_TRACE:   cxs_vector = cxs_pkg::CXS_VEC_TRACE;
            cxs_pkg::CXS_EX_FORMAT:  cxs_vector = cxs_pkg::CXS_VEC_FORMAT;
            cxs_pkg::CXS_EX_OPCODE: begin
                if (r.opcode[15:12] == cxs_pkg::CXS_OPC_LINE_A) begin
                    cxs_vector = cxs_pkg::CXS_VEC_LINE_A;
                end else if (r.opcode[15:12] == cxs_pkg::CXS_OPC_LINE_F) begin
                    cxs_vector = cxs_pkg::CXS_VEC_LINE_F;
                end else begin
                    cxs_vector = cxs_pkg::CXS_VEC_ILLEGAL;
                end
            end
            cxs_pkg::CXS_EX_TRAP:    cxs_vector = cxs_pkg::CXS_VEC_TRAP0 + {4'h0, r.trapNum};
            cxs_pkg::CXS_EX_USER: begin
                // User range only; lower numbers fall back to the user base
                cxs_vector = (r.userVec < cxs_pkg::CXS_VEC_USER0) ?
                             cxs_pkg::CXS_VEC_USER0 : r.userVec;
            end
            default:                 cxs_vector = cxs_pkg::CXS_VEC_ILLEGAL;
        endcase
    endfunction

    // Byte address of a vector entry (word half selects high/low)
    function automatic logic [23:0] cxs_vec_addr(input logic [7:0] v, input logic lo);
        cxs_vec_addr = cxs_pkg::CXS_TABLE_BASE + {14'h0, v, lo, 1'b0};
    endfunction

    cxs_pkg::cxs_state_t stateQ;
    logic                isResetQ;
    logic [15:0]         savedSwQ;
    logic [31:0]         retPcQ;
    logic [15:0]         pcHiQ;
    logic [15:0]         sspHiQ;
    logic                rstSeenQ;

    logic [2:0] curMask;
    logic       irqTake;
    logic       excTake;
    assign curMask = statusWord[cxs_pkg::CXS_SW_IPL_LSB +: 3];
    assign irqTake = instrBoundary && (priorityRequestLines > curMask);
    assign excTake = excReq && (excInfo.cause != cxs_pkg::CXS_EX_NONE);

    // Sequencer: reset path fetches stack pointer then counter, others push then vector
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            stateQ    <= cxs_pkg::CXS_ST_IDLE;
            isResetQ  <= 1'b1;
            rstSeenQ  <= 1'b1;
        end else begin
            case (stateQ)
                cxs_pkg::CXS_ST_IDLE: begin
                    if (rstSeenQ) begin
                        rstSeenQ <= 1'b0;
                        isResetQ <= 1'b1;
                        stateQ   <= cxs_pkg::CXS_ST_SSPHI;
                    end else if (excTake) begin
                        // Synchronous faults outrank a pending interrupt
                        isResetQ <= 1'b0;
                        stateQ   <= cxs_pkg::CXS_ST_PUSHLO;
                    end else if (irqTake) begin
                        isResetQ <= 1'b0;
                        stateQ   <= cxs_pkg::CXS_ST_PUSHLO;
                    end
                end
                cxs_pkg::CXS_ST_PUSHLO: if (memAck) stateQ <= cxs_pkg::CXS_ST_PUSHHI;
                cxs_pkg::CXS_ST_PUSHHI: if (memAck) stateQ <= cxs_pkg::CXS_ST_PUSHSW;
                cxs_pkg::CXS_ST_PUSHSW: if (memAck) stateQ <= cxs_pkg::CXS_ST_VECHI;
                cxs_pkg::CXS_ST_SSPHI:  if (memAck) stateQ <= cxs_pkg::CXS_ST_SSPLO;
                cxs_pkg::CXS_ST_SSPLO:  if (memAck) stateQ <= cxs_pkg::CXS_ST_VECHI;
                cxs_pkg::CXS_ST_VECHI:  if (memAck) stateQ <= cxs_pkg::CXS_ST_VECLO;
                cxs_pkg::CXS_ST_VECLO:  if (memAck) stateQ <= cxs_pkg::CXS_ST_DONE;
                cxs_pkg::CXS_ST_DONE:   stateQ <= cxs_pkg::CXS_ST_IDLE;
                default:                stateQ <= cxs_pkg::CXS_ST_IDLE;
            endcase
        end
    end

    // Handshake and vector number outputs
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            excAccept    <= 1'b0;
            vectorNumber <= 8'h00;
        end else begin
            excAccept <= 1'b0;
            if (stateQ == cxs_pkg::CXS_ST_IDLE) begin
                if (rstSeenQ) begin
                    vectorNumber <= cxs_pkg::CXS_VEC_RESET_SP;
                end else if (excTake) begin
                    excAccept    <= 1'b1;
                    vectorNumber <= cxs_vector(excInfo);
                end else if (irqTake) begin
                    vectorNumber <= cxs_pkg::CXS_VEC_AUTO0 + {5'h00, priorityRequestLines};
                end
            end else if (stateQ == cxs_pkg::CXS_ST_SSPLO && memAck) begin
                vectorNumber <= cxs_pkg::CXS_VEC_RESET_PC;
            end
        end
    end

    // Status word: copy, supervisor on, trace off, mask update for reset and interrupt
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            statusWord <= cxs_pkg::CXS_SW_RESET;
            savedSwQ   <= 16'h0000;
        end else if (stateQ == cxs_pkg::CXS_ST_IDLE && !rstSeenQ && (excTake || irqTake)) begin
            savedSwQ <= statusWord;
            statusWord[cxs_pkg::CXS_SW_S_BIT] <= 1'b1;
            statusWord[cxs_pkg::CXS_SW_T_BIT] <= 1'b0;
            if (!excTake) begin
                statusWord[cxs_pkg::CXS_SW_IPL_LSB +: 3] <= priorityRequestLines;
            end
        end else if (stateQ == cxs_pkg::CXS_ST_IDLE && rstSeenQ) begin
            statusWord <= cxs_pkg::CXS_SW_RESET;
        end else if (stateQ == cxs_pkg::CXS_ST_IDLE && statusWordLoad) begin
            statusWord <= statusWordIn;
        end
    end

    // Return address, stack pointer and fetched words
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            retPcQ                 <= 32'h0000_0000;
            supervisorStackPointer <= 32'h0000_0000;
            pcHiQ                  <= 16'h0000;
            sspHiQ                 <= 16'h0000;
            newPc                  <= 32'h0000_0000;
        end else begin
            if (stateQ == cxs_pkg::CXS_ST_IDLE && !rstSeenQ && (excTake || irqTake)) begin
                retPcQ                 <= excInfo.retPc;
                supervisorStackPointer <= supStackIn;
            end
            if (memAck) begin
                case (stateQ)
                    cxs_pkg::CXS_ST_PUSHLO,
                    cxs_pkg::CXS_ST_PUSHHI,
                    cxs_pkg::CXS_ST_PUSHSW: begin
                        supervisorStackPointer <= supervisorStackPointer - 32'h0000_0002;
                    end
                    cxs_pkg::CXS_ST_SSPHI: sspHiQ <= memRdata;
                    cxs_pkg::CXS_ST_SSPLO: supervisorStackPointer <= {sspHiQ, memRdata};
                    cxs_pkg::CXS_ST_VECHI: pcHiQ <= memRdata;
                    cxs_pkg::CXS_ST_VECLO: newPc <= {pcHiQ, memRdata};
                    default: ;
                endcase
            end
        end
    end

    // Memory bus request: stacking predecrements, vector words read high then low
    // The reset path reads the stack pointer before the counter; pushes precede the
    // vector read, which this order is free to choose.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            memBus      <= '0;
            resumeFetch <= 1'b0;
            busy        <= 1'b1;
        end else begin
            resumeFetch <= (stateQ == cxs_pkg::CXS_ST_VECLO) && memAck;
            // Busy drops with the resume pulse and stays low through the closing state
            busy        <= !((stateQ == cxs_pkg::CXS_ST_VECLO) && memAck) &&
                           ((stateQ == cxs_pkg::CXS_ST_IDLE) ? (rstSeenQ || excTake || irqTake)
                                                             : (stateQ != cxs_pkg::CXS_ST_DONE));
            memBus.valid <= 1'b0;
            memBus.write <= 1'b0;
            memBus.space <= cxs_pkg::CXS_FC_SUP_DATA;
            memBus.addr  <= 24'h00_0000;
            memBus.wdata <= 16'h0000;
            case (stateQ)
                cxs_pkg::CXS_ST_PUSHLO: begin
                    memBus.valid <= 1'b1;
                    memBus.write <= 1'b1;
                    memBus.addr  <= supervisorStackPointer[23:0] - 24'h00_0002;
                    memBus.wdata <= retPcQ[15:0];
                end
                cxs_pkg::CXS_ST_PUSHHI: begin
                    memBus.valid <= 1'b1;
                    memBus.write <= 1'b1;
                    memBus.addr  <= supervisorStackPointer[23:0] - 24'h00_0002;
                    memBus.wdata <= retPcQ[31:16];
                end
                cxs_pkg::CXS_ST_PUSHSW: begin
                    memBus.valid <= 1'b1;
                    memBus.write <= 1'b1;
                    memBus.addr  <= supervisorStackPointer[23:0] - 24'h00_0002;
                    memBus.wdata <= savedSwQ;
                end
                cxs_pkg::CXS_ST_SSPHI, cxs_pkg::CXS_ST_SSPLO: begin
                    memBus.valid <= 1'b1;
                    memBus.space <= cxs_pkg::CXS_FC_SUP_PROG;
                    memBus.addr  <= cxs_vec_addr(cxs_pkg::CXS_VEC_RESET_SP,
                                                 stateQ == cxs_pkg::CXS_ST_SSPLO);
                end
                cxs_pkg::CXS_ST_VECHI, cxs_pkg::CXS_ST_VECLO: begin
                    memBus.valid <= 1'b1;
                    memBus.space <= isResetQ ? cxs_pkg::CXS_FC_SUP_PROG
                                             : cxs_pkg::CXS_FC_SUP_DATA;
                    memBus.addr  <= cxs_vec_addr(vectorNumber,
                                                 stateQ == cxs_pkg::CXS_ST_VECLO);
                end
                default: ;
            endcase
        end
    end

endmodule

`default_nettype wire

//--- pkg/cxs_pkg.sv
// Purpose: Shared constants and types for the core exception sequencer
// Assumes: 20 MHz core clock, 16-bit memory bus with word addressing by byte
// Notes:   Vector numbers are decimal; offsets are byte addresses from table base
package cxs_pkg;

    localparam logic [23:0] CXS_TABLE_BASE   = 24'h00_0000;
    localparam int          CXS_TABLE_WORDS  = 512;
    localparam int          CXS_TABLE_BYTES  = 1024;

    localparam logic [7:0]  CXS_VEC_RESET_SP = 8'h00;
    localparam logic [7:0]  CXS_VEC_RESET_PC = 8'h01;
    localparam logic [7:0]  CXS_VEC_ADDRERR  = 8'h03;
    localparam logic [7:0]  CXS_VEC_ILLEGAL  = 8'h04;
    localparam logic [7:0]  CXS_VEC_DIVZERO  = 8'h05;
    localparam logic [7:0]  CXS_VEC_BOUNDS   = 8'h06;
    localparam logic [7:0]  CXS_VEC_OVFTRAP  = 8'h07;
    localparam logic [7:0]  CXS_VEC_PRIV     = 8'h08;
    localparam logic [7:0]  CXS_VEC_TRACE    = 8'h09;
    localparam logic [7:0]  CXS_VEC_LINE_A   = 8'h0A;
    localparam logic [7:0]  CXS_VEC_LINE_F   = 8'h0B;
    localparam logic [7:0]  CXS_VEC_FORMAT   = 8'h0E;
    localparam logic [7:0]  CXS_VEC_AUTO0    = 8'h18;
    localparam logic [7:0]  CXS_VEC_TRAP0    = 8'h20;
    localparam logic [7:0]  CXS_VEC_USER0    = 8'h40;

    localparam logic [3:0]  CXS_OPC_LINE_A   = 4'hA;
    localparam logic [3:0]  CXS_OPC_LINE_F   = 4'hF;

    localparam int          CXS_SW_S_BIT     = 13;
    localparam int          CXS_SW_T_BIT     = 15;
    localparam int          CXS_SW_IPL_LSB   = 8;
    localparam logic [15:0] CXS_SW_RESET     = 16'h2700;
    localparam logic [2:0]  CXS_IPL_MAX      = 3'h7;

    localparam logic [2:0]  CXS_FC_SUP_DATA  = 3'h5;
    localparam logic [2:0]  CXS_FC_SUP_PROG  = 3'h6;

    typedef enum logic [3:0] {
        CXS_EX_NONE    = 4'h0,
        CXS_EX_ADDRERR = 4'h1,
        CXS_EX_ILLEGAL = 4'h2,
        CXS_EX_DIVZERO = 4'h3,
        CXS_EX_BOUNDS  = 4'h4,
        CXS_EX_OVFTRAP = 4'h5,
        CXS_EX_PRIV    = 4'h6,
        CXS_EX_TRACE   = 4'h7,
        CXS_EX_OPCODE  = 4'h8,
        CXS_EX_TRAP    = 4'h9,
        CXS_EX_FORMAT  = 4'hA,
        CXS_EX_USER    = 4'hB
    } cxs_cause_t;

    typedef enum logic [3:0] {
        CXS_ST_IDLE   = 4'h0,
        CXS_ST_PUSHLO = 4'h1,
        CXS_ST_PUSHHI = 4'h2,
        CXS_ST_PUSHSW = 4'h3,
        CXS_ST_VECHI  = 4'h4,
        CXS_ST_VECLO  = 4'h5,
        CXS_ST_SSPHI  = 4'h6,
        CXS_ST_SSPLO  = 4'h7,
        CXS_ST_DONE   = 4'h8
    } cxs_state_t;

    typedef struct packed {
        cxs_cause_t  cause;
        logic [3:0]  trapNum;
        logic [15:0] opcode;
        logic [7:0]  userVec;
        logic [31:0] retPc;
    } cxs_req_t;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [2:0]  space;
        logic [23:0] addr;
        logic [15:0] wdata;
    } cxs_bus_t;

endpackage

//--- tb/cxs_sequencer_assertions.sv
// Purpose: Port-level checks for the exception sequencer
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound into every cxs_sequencer instance
`timescale 1ns/1ps
`default_nettype none
module cxs_sequencer_assertions (
    input wire logic              clk,
    input wire logic              sys_rst,
    input wire logic              instrBoundary,
    input wire logic              excReq,
    input wire cxs_pkg::cxs_req_t excInfo,
    input wire logic [2:0]        priorityRequestLines,
    input wire logic [15:0]       statusWordIn,
    input wire logic              statusWordLoad,
    input wire logic [31:0]       supStackIn,
    input wire logic              memAck,
    input wire logic [15:0]       memRdata,
    input wire cxs_pkg::cxs_bus_t memBus,
    input wire logic [15:0]       statusWord,
    input wire logic [31:0]       supervisorStackPointer,
    input wire logic [31:0]       newPc,
    input wire logic              resumeFetch,
    input wire logic              busy,
    input wire logic              excAccept,
    input wire logic [7:0]        vectorNumber
);
    logic [2:0] maskNow;
    assign maskNow = statusWord[10:8];
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    property p_accept_idle; excAccept |-> !$past(busy) ##1 busy; endproperty
    a_accept_idle: assert property (p_accept_idle) else $error("accept while busy");
    property p_irq_gate;
        $rose(busy) && !$past(excReq) |-> $past(instrBoundary)
            && ($past(priorityRequestLines) > $past(maskNow));
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("interrupt taken at or below mask");
    property p_sup_state; resumeFetch |-> statusWord[13] && !statusWord[15]; endproperty
    a_sup_state: assert property (p_sup_state) else $error("handler not supervisor");
    property p_vec_addr;
        memBus.valid && !memBus.write && memBus.space == cxs_pkg::CXS_FC_SUP_DATA
            |-> memBus.addr[23:10] == 14'h0000 && memBus.addr[9:2] == vectorNumber;
    endproperty
    a_vec_addr: assert property (p_vec_addr) else $error("vector address wrong");
    property p_prog_space;
        memBus.valid && memBus.space == cxs_pkg::CXS_FC_SUP_PROG
            |-> !memBus.write && memBus.addr < 24'h00_0008;
    endproperty
    a_prog_space: assert property (p_prog_space) else $error("program space misuse");
    property p_frame_start;
        excAccept |=> memBus.valid && memBus.write
            && memBus.addr == supStackIn[23:0] - 24'h00_0002;
    endproperty
    a_frame_start: assert property (p_frame_start) else $error("frame push missing");
    property p_pc_word; resumeFetch |-> $past(memAck) && newPc[15:0] == $past(memRdata); endproperty
    a_pc_word: assert property (p_pc_word) else $error("new pc not from vector");
    property p_resume_pulse; resumeFetch |=> !resumeFetch; endproperty
    a_resume_pulse: assert property (p_resume_pulse) else $error("resume not a pulse");

    c_irq: cover property ($rose(busy) && !$past(excReq));
    c_user: cover property (resumeFetch && vectorNumber >= 8'h40);
    c_push: cover property (memBus.valid && memBus.write && memAck);
endmodule
bind cxs_sequencer cxs_sequencer_assertions u_cxs_chk (
    .clk(clk), .sys_rst(sys_rst), .instrBoundary(instrBoundary), .excReq(excReq),
    .excInfo(excInfo), .priorityRequestLines(priorityRequestLines),
    .statusWordIn(statusWordIn), .statusWordLoad(statusWordLoad), .supStackIn(supStackIn),
    .memAck(memAck), .memRdata(memRdata), .memBus(memBus), .statusWord(statusWord),
    .supervisorStackPointer(supervisorStackPointer), .newPc(newPc),
    .resumeFetch(resumeFetch), .busy(busy), .excAccept(excAccept),
    .vectorNumber(vectorNumber)
);
`default_nettype wire

//--- tb/cxs_mem_model.sv
// Purpose: Memory partner answering the sequencer's bus
// Assumes: Request stands until the cycle after the ack edge
// Notes:   Read data toggles when not acked so stale values never match
`timescale 1ns/1ps
`default_nettype none
module cxs_mem_model (
    input  wire logic              clk,
    input  wire logic              sys_rst,
    input  wire cxs_pkg::cxs_bus_t memBus,
    output logic                   memAck,
    output logic [15:0]            memRdata
);
    logic [1:0] coolQ;
    logic [1:0] waitQ;
    logic [1:0] latQ;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            memAck <= 1'b0;
            coolQ <= 2'h0;
            waitQ <= 2'h0;
            latQ <= 2'h0;
            memRdata <= 16'hffff;
        end else begin
            memAck <= 1'b0;
            memRdata <= ~memRdata;
            // Skip the two stale request cycles that follow an ack
            if (coolQ != 2'h0) begin
                coolQ <= coolQ - 2'h1;
                waitQ <= 2'h0;
            end else if (memBus.valid) begin
                if (waitQ == latQ) begin
                    memAck <= 1'b1;
                    coolQ <= 2'h2;
                    waitQ <= 2'h0;
                    latQ <= 2'($urandom_range(0, 2));
                    memRdata <= memBus.addr[15:0] ^ 16'h5a3c;
                end else begin
                    waitQ <= waitQ + 2'h1;
                end
            end
        end
    end
endmodule
`default_nettype wire

//--- tb/core_exception_sequencer_test.sv
// Purpose: Self-checking bench for the exception sequencer
// Assumes: Memory partner acks after one to three cycles
// Notes:   Frames, vectors and status are rebuilt from the stimulus
`timescale 1ns/1ps
`default_nettype none
module core_exception_sequencer_test;
    logic              clk = 1'b0, sysRst = 1'b1, instrBoundary = 1'b0, excReq = 1'b0;
    logic              swLoad = 1'b0, memAck, resumeFetch, busy, excAccept;
    cxs_pkg::cxs_req_t excInfo = '0;
    logic [2:0]        irqLevel = 3'h0;
    logic [15:0]       swIn = 16'h0000, memRdata, statusWord, swModel;
    logic [31:0]       sspIn = 32'h0000_0000, supervisor_stack_pointer, newPc;
    logic [7:0]        vecNum;
    cxs_pkg::cxs_bus_t memBus, seen, busLog[$], expLog[$];
    int                errorCnt = 0, checked = 0;

    initial begin
        forever #25 clk = ~clk;
    end
    cxs_sequencer dut (.clk(clk), .sys_rst(sysRst), .instrBoundary(instrBoundary),
        .excReq(excReq), .excInfo(excInfo), .priorityRequestLines(irqLevel),
        .statusWordIn(swIn), .statusWordLoad(swLoad), .supStackIn(sspIn), .memAck(memAck),
        .memRdata(memRdata), .memBus(memBus), .statusWord(statusWord),
        .supervisorStackPointer(supervisor_stack_pointer), .newPc(newPc), .resumeFetch(resumeFetch),
        .busy(busy), .excAccept(excAccept), .vectorNumber(vecNum));
    cxs_mem_model u_mem (.clk(clk), .sys_rst(sysRst), .memBus(memBus), .memAck(memAck),
        .memRdata(memRdata));

    always @(posedge clk) begin
        if (memBus.valid === 1'b1 && memAck === 1'b1) begin
            seen = memBus;
            if (!seen.write) seen.wdata = 16'h0000;
            busLog.push_back(seen);
        end
    end

    function automatic logic [15:0] memWord(input logic [23:0] a);
        return a[15:0] ^ 16'h5a3c;
    endfunction
    function automatic cxs_pkg::cxs_bus_t cyc(input logic w, input logic [2:0] s,
                                              input logic [23:0] a, input logic [15:0] d);
        return {1'b1, w, s, a, d};
    endfunction
    task automatic check(input logic [63:0] got, input logic [63:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            errorCnt++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic finish_test();
        if (errorCnt == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic wait_high(ref logic s);
        repeat (200) begin
            @(posedge clk);
            if (s === 1'b1) return;
        end
        check(64'h0, 64'h1, "wait timeout");
        finish_test();
    endtask
    task automatic check_log();
        check(64'(busLog.size()), 64'(expLog.size()), "bus cycle count");
        foreach (expLog[i]) check(64'(busLog[i]), 64'(expLog[i]), "bus cycle");
        busLog.delete();
    endtask
    task automatic load_sw(input logic [15:0] v);
        swIn <= v;
        swLoad <= 1'b1;
        @(posedge clk);
        swLoad <= 1'b0;
        @(posedge clk);
        swModel = v;
        check(64'(statusWord), 64'(v), "status load");
    endtask
    task automatic no_take(input logic [2:0] lvl, input logic bnd);
        int hits;
        hits = 0;
        irqLevel <= lvl;
        instrBoundary <= bnd;
        repeat (12) begin
            @(posedge clk);
            if (busy !== 1'b0) hits++;
        end
        check(64'(hits), 64'h0, "interrupt taken");
    endtask
    task automatic run_exc(input cxs_pkg::cxs_cause_t c, input logic [7:0] v, input logic [2:0] l);
        logic [31:0] pc;
        logic [31:0] sp;
        logic [23:0] va;
        pc = $urandom;
        sp = 32'h0000_8000 + 32'($urandom_range(0, 4095)) * 32'h0000_0002;
        va = {14'h0000, v, 2'b00};
        excInfo.cause <= c;
        excInfo.retPc <= pc;
        sspIn <= sp;
        excReq <= (c != cxs_pkg::CXS_EX_NONE);
        irqLevel <= l;
        instrBoundary <= 1'b1;
        if (c == cxs_pkg::CXS_EX_NONE) wait_high(busy);
        else wait_high(excAccept);
        excReq <= 1'b0;
        irqLevel <= 3'h0;
        instrBoundary <= 1'b0;
        wait_high(resumeFetch);
        expLog = '{cyc(1'b1, 3'h5, sp[23:0] - 24'h00_0002, pc[15:0]),
                   cyc(1'b1, 3'h5, sp[23:0] - 24'h00_0004, pc[31:16]),
                   cyc(1'b1, 3'h5, sp[23:0] - 24'h00_0006, swModel),
                   cyc(1'b0, 3'h5, va, 16'h0000), cyc(1'b0, 3'h5, va + 24'h00_0002, 16'h0000)};
        check_log();
        swModel[15] = 1'b0;
        swModel[13] = 1'b1;
        if (l != 3'h0) swModel[10:8] = l;
        check(64'(statusWord), 64'(swModel), "entry status");
        check(64'(vecNum), 64'(v), "vector number");
        check(64'(newPc), 64'({memWord(va), memWord(va + 24'h00_0002)}), "new pc");
        check(64'(supervisor_stack_pointer), 64'(sp - 32'h0000_0006), "stack pointer");
    endtask

    initial begin
        logic [7:0] u;
        u = 8'($urandom(32'h0000_610c));
        repeat (16) @(posedge clk);
        sysRst <= 1'b0;
        swModel = 16'h2700;
        wait_high(resumeFetch);
        for (int a = 0; a < 8; a += 2) expLog.push_back(cyc(1'b0, 3'h6, 24'(a), 16'h0000));
        check_log();
        check(64'(supervisor_stack_pointer), 64'({memWord(24'h00_0000), memWord(24'h00_0002)}), "reset sp");
        check(64'(newPc), 64'({memWord(24'h00_0004), memWord(24'h00_0006)}), "reset pc");
        check(64'(statusWord), 64'h0000_0000_0000_2700, "reset status");
        for (int k = 1; k <= 10; k++) begin
            if (k == 8 || k == 9) continue;
            load_sw(16'($urandom) & 16'ha01f);
            run_exc(cxs_pkg::cxs_cause_t'(k), (k == 10) ? 8'h0e : 8'(k + 2), 3'h0);
        end
        for (int k = 0; k < 3; k++) begin
            excInfo.opcode <= {k[1] ? 4'h4 : (k[0] ? 4'hf : 4'ha), 12'($urandom)};
            run_exc(cxs_pkg::CXS_EX_OPCODE, k[1] ? 8'h04 : (k[0] ? 8'h0b : 8'h0a), 3'h0);
        end
        for (int n = 0; n < 16; n++) begin
            excInfo.trapNum <= 4'(n);
            run_exc(cxs_pkg::CXS_EX_TRAP, 8'(32 + n), 3'h0);
        end
        for (int k = 0; k < 4; k++) begin
            // Below-range user numbers fold onto the first user vector
            u = k[0] ? 8'h40 + 8'($urandom_range(0, 191)) : (k[1] ? 8'hff : 8'h0c);
            excInfo.userVec <= u;
            run_exc(cxs_pkg::CXS_EX_USER, (u < 8'h40) ? 8'h40 : u, 3'h0);
        end
        load_sw(16'h0300);
        no_take(3'h3, 1'b1);
        no_take(3'h5, 1'b0);
        run_exc(cxs_pkg::CXS_EX_NONE, 8'h1d, 3'h5);
        for (int k = 1; k <= 7; k++) begin
            load_sw(16'($urandom) & 16'ha01f);
            run_exc(cxs_pkg::CXS_EX_NONE, 8'(24 + k), 3'(k));
        end
        finish_test();
    end
endmodule
`default_nettype wire
